// [rtl/mcuiet_pkg.sv]
package mcuiet_pkg;
  // Instruction cycle phases
  localparam int          PHASES_PER_CYCLE = 4;
  localparam logic [1:0]  PHASE_LAST       = 2'h3;
  localparam int          PC_W             = 12;
  localparam int          RAM_AW           = 8;
  localparam logic [7:0]  PC_LOW_ADDR      = 8'h06;
  localparam logic [7:0]  BYTE_MAX         = 8'hFF;
  localparam logic [7:0]  BYTE_ONE         = 8'h01;

  // Instruction fields
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 12;
  localparam int SUB_MSB = 11;
  localparam int SUB_LSB = 8;
  localparam int BIT_MSB = 10;
  localparam int BIT_LSB = 8;

  typedef enum logic [3:0] {
    MCUIET_OP_ALU_M  = 4'h0,
    MCUIET_OP_ALU_X  = 4'h1,
    MCUIET_OP_MOVE_AM = 4'h2,
    MCUIET_OP_MOVE_MA = 4'h3,
    MCUIET_OP_MOVE_AX = 4'h4,
    MCUIET_OP_BSET   = 4'h5,
    MCUIET_OP_BCLR   = 4'h6,
    MCUIET_OP_SZB    = 4'h7,
    MCUIET_OP_SNZB   = 4'h8,
    MCUIET_OP_JUMP   = 4'h9,
    MCUIET_OP_CALL   = 4'hA,
    MCUIET_OP_RETURN = 4'hB,
    MCUIET_OP_TABRD  = 4'hC,
    MCUIET_OP_HALT   = 4'hD,
    MCUIET_OP_WDTCLR = 4'hE,
    MCUIET_OP_SZ     = 4'hF
  } mcuiet_op_t;

  // ALU sub-operations; bit 3 of sub selects memory destination for the memory form only
  typedef enum logic [2:0] {
    MCUIET_ALU_ADD = 3'h0,
    MCUIET_ALU_SUB = 3'h1,
    MCUIET_ALU_AND = 3'h2,
    MCUIET_ALU_OR  = 3'h3,
    MCUIET_ALU_XOR = 3'h4,
    MCUIET_ALU_COMPL = 3'h5,
    MCUIET_ALU_INC   = 3'h6,
    MCUIET_ALU_DECR  = 3'h7
  } mcuiet_alu_t;

  typedef enum logic [1:0] {
    MCUIET_ST_RUN   = 2'h0,
    MCUIET_ST_FLUSH = 2'h1,
    MCUIET_ST_HALT  = 2'h2
  } mcuiet_state_t;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic            table_rd;
  } mcuiet_fetch_t;

  typedef struct packed {
    logic zero;
    logic carry;
  } mcuiet_flags_t;
endpackage

// [rtl/mcuiet_core.sv]
`timescale 1ns/100ps
`default_nettype none
module mcuiet_core #(
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic                        CLK_IN,
  input  wire logic                        RST_B_IN,
  // Program memory
  output var mcuiet_pkg::mcuiet_fetch_t    FETCH_OUT,
  input  wire logic [15:0]                 PROG_DATA_IN,
  // Status
  output logic [7:0]                       ACC_OUT,
  output var mcuiet_pkg::mcuiet_flags_t    FLAGS_OUT,
  output logic [7:0]                       TABLE_DATA_OUT,
  output logic                             CYCLE_END_OUT,
  output logic                             HALTED_OUT,
  output logic                             WDT_CLEAR_OUT
);
  import mcuiet_pkg::*;

  logic [7:0]      ram [RAM_DEPTH];
  logic [1:0]      phase_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] ret_r;
  logic [15:0]     ir_r;
  logic [7:0]      acc_r;
  mcuiet_flags_t   flags_r;
  mcuiet_state_t   state_r;
  mcuiet_state_t   state_nxt;
  mcuiet_fetch_t   fetch_r;
  logic [7:0]      tab_r;
  logic            tab_pend_r;
  logic            cyc_end_r;
  logic            wdt_r;
  logic            halted_r;

  wire cyc_end = (phase_r == PHASE_LAST);
  wire [3:0] op_w  = ir_r[OP_MSB:OP_LSB];
  wire [3:0] sub_w = ir_r[SUB_MSB:SUB_LSB];
  wire [2:0] bit_w = ir_r[BIT_MSB:BIT_LSB];
  wire [7:0] m_addr = ir_r[7:0];
  wire [7:0] m_val  = ram[m_addr];
  wire [7:0] imm    = ir_r[7:0];
  wire       exec   = cyc_end && (state_r == MCUIET_ST_RUN);

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b);
    add9 = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic [7:0] bitmask(input logic [2:0] i);
    bitmask = BYTE_ONE << i;
  endfunction

  // Operand select and ALU
  wire [7:0] opnd = (op_w == MCUIET_OP_ALU_X) ? imm : m_val;
  wire [2:0] aop  = sub_w[2:0];
  wire       to_m = sub_w[3] && (op_w == MCUIET_OP_ALU_M);
  wire [8:0] sum  = add9(acc_r, opnd);
  wire [8:0] dif  = add9(acc_r, ~opnd) + 9'h001;
  // Plain rotates wrap the outgoing bit; carry forms feed the old carry in
  wire       rin_r = imm[5] ? flags_r.carry : opnd[0];
  wire       rin_l = imm[5] ? flags_r.carry : opnd[7];
  wire [8:0] rotr = {opnd[0], rin_r, opnd[7:1]};
  wire [8:0] rotl = {opnd[7], opnd[6:0], rin_l};
  logic [7:0] res;
  logic       res_c;
  logic       c_upd;
  always_comb begin
    res   = 8'h00;
    res_c = flags_r.carry;
    c_upd = 1'b0;
    case (aop)
      MCUIET_ALU_ADD: begin res = sum[7:0]; res_c = sum[8]; c_upd = 1'b1; end
      MCUIET_ALU_SUB: begin res = dif[7:0]; res_c = dif[8]; c_upd = 1'b1; end
      MCUIET_ALU_AND: res = acc_r & opnd;
      MCUIET_ALU_OR:  res = acc_r | opnd;
      MCUIET_ALU_XOR: begin
        // Rotate forms share XOR slot on immediate encoding
        if (op_w == MCUIET_OP_ALU_X && imm[7]) begin
          res = imm[6] ? rotl[7:0] : rotr[7:0];
          res_c = imm[6] ? rotl[8] : rotr[8];
          c_upd = imm[5];
        end else begin
          res = acc_r ^ opnd;
        end
      end
      MCUIET_ALU_COMPL: res = ~opnd;
      MCUIET_ALU_INC:   res = opnd + BYTE_ONE;
      MCUIET_ALU_DECR:  res = opnd - BYTE_ONE;
      default:        res = 8'h00;
    endcase
  end

  // Skip and flow decisions
  wire [7:0] bset_v = m_val | bitmask(bit_w);
  wire [7:0] bclr_v = m_val & ~bitmask(bit_w);
  wire skip_w = (op_w == MCUIET_OP_SZB  && !m_val[bit_w]) ||
                (op_w == MCUIET_OP_SNZB &&  m_val[bit_w]) ||
                (op_w == MCUIET_OP_SZ   &&  m_val == 8'h00);
  wire wr_m  = to_m || op_w == MCUIET_OP_MOVE_MA ||
               op_w == MCUIET_OP_BSET || op_w == MCUIET_OP_BCLR;
  wire [7:0] wr_v = (op_w == MCUIET_OP_MOVE_MA) ? acc_r :
                    (op_w == MCUIET_OP_BSET) ? bset_v :
                    (op_w == MCUIET_OP_BCLR) ? bclr_v : res;
  wire pc_low_wr = wr_m && (m_addr == PC_LOW_ADDR);
  wire is_alu = op_w == MCUIET_OP_ALU_M || op_w == MCUIET_OP_ALU_X;
  wire is_jmp = op_w == MCUIET_OP_JUMP || op_w == MCUIET_OP_CALL;
  wire is_tab = op_w == MCUIET_OP_TABRD;
  wire flow_w = is_jmp || op_w == MCUIET_OP_RETURN || pc_low_wr ||
                skip_w || is_tab;
  // Next sequential address is the one already prefetched
  wire [PC_W-1:0] tgt = ir_r[PC_W-1:0];
  logic [PC_W-1:0] pc_nxt;
  always_comb begin
    pc_nxt    = pc_r + 12'h001;
    state_nxt = state_r;
    if (cyc_end) begin
      case (state_r)
        MCUIET_ST_RUN: begin
          if (is_jmp) begin
            pc_nxt = tgt;
            state_nxt = MCUIET_ST_FLUSH;
          end else if (op_w == MCUIET_OP_RETURN) begin
            pc_nxt = ret_r;
            state_nxt = MCUIET_ST_FLUSH;
          end else if (pc_low_wr) begin
            pc_nxt = {pc_r[PC_W-1:8], wr_v};
            state_nxt = MCUIET_ST_FLUSH;
          end else if (skip_w) begin
            state_nxt = MCUIET_ST_FLUSH;
          end else if (is_tab) begin
            // Hold the counter so the discarded prefetch is fetched again
            pc_nxt = pc_r;
            state_nxt = MCUIET_ST_FLUSH;
          end else if (op_w == MCUIET_OP_HALT) begin
            pc_nxt = pc_r;
            state_nxt = MCUIET_ST_HALT;
          end
        end
        MCUIET_ST_FLUSH: state_nxt = MCUIET_ST_RUN;
        MCUIET_ST_HALT:  pc_nxt = pc_r;
        default:         state_nxt = MCUIET_ST_RUN;
      endcase
    end else begin
      pc_nxt = pc_r;
    end
  end

  // Fetch address: table pointer in the first clock of the flush of a table read
  wire tab_fetch = exec && is_tab;
  wire [PC_W-1:0] tab_addr = {acc_r[3:0], m_val};
  mcuiet_fetch_t  fetch_nxt;
  assign fetch_nxt = tab_fetch ? mcuiet_fetch_t'{tab_addr, 1'b1} :
                                 mcuiet_fetch_t'{pc_nxt, 1'b0};

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      pc_r       <= '0;
      ret_r      <= '0;
      ir_r       <= '0;
      state_r    <= MCUIET_ST_FLUSH;
      fetch_r    <= '0;
      tab_pend_r <= 1'b0;
      cyc_end_r  <= 1'b0;
      halted_r   <= 1'b0;
    end else begin
      pc_r       <= pc_nxt;
      state_r    <= state_nxt;
      halted_r   <= (state_nxt == MCUIET_ST_HALT);
      cyc_end_r  <= cyc_end;
      fetch_r    <= fetch_nxt;
      if (exec && op_w == MCUIET_OP_CALL) begin
        ret_r <= pc_r;
      end
      if (cyc_end) begin
        tab_pend_r <= tab_fetch;
        // A flushed or halted cycle loads a no-op over the prefetch
        ir_r <= (state_nxt == MCUIET_ST_RUN) ? PROG_DATA_IN :
                {MCUIET_OP_WDTCLR, 12'hFFF};
      end
    end
  end

  // Accumulator, flags, memory
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      acc_r   <= 8'h00;
      flags_r <= '0;
      tab_r   <= 8'h00;
      wdt_r   <= 1'b0;
    end else begin
      wdt_r <= exec && op_w == MCUIET_OP_WDTCLR && !ir_r[0];
      // Table word stands on the bus only in the first flush clock
      if (cyc_end_r && tab_pend_r) begin
        tab_r <= PROG_DATA_IN[7:0];
      end
      if (exec) begin
        case (op_w)
          MCUIET_OP_MOVE_AM: acc_r <= m_val;
          MCUIET_OP_MOVE_AX: acc_r <= imm;
          default: begin
            if (is_alu && !to_m) begin
              acc_r <= res;
            end
          end
        endcase
        if (is_alu) begin
          flags_r.zero <= (res == 8'h00);
          if (c_upd) begin
            flags_r.carry <= res_c;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (exec && wr_m) begin
      ram[m_addr] <= wr_v;
    end
  end

  assign FETCH_OUT      = fetch_r;
  assign ACC_OUT        = acc_r;
  assign FLAGS_OUT      = flags_r;
  assign TABLE_DATA_OUT = tab_r;
  assign CYCLE_END_OUT  = cyc_end_r;
  assign HALTED_OUT     = halted_r;
  assign WDT_CLEAR_OUT  = wdt_r;

  // Checks
  sequence s_flow_op;
    exec && flow_w;
  endsequence

  sequence s_table_op;
    exec && is_tab;
  endsequence

  a_phase_wrap: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    cyc_end |=> !cyc_end [*3] ##1 cyc_end)
    else $error("instruction cycle not four clocks");
  a_flow_flush: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    s_flow_op |=> state_r == MCUIET_ST_FLUSH)
    else $error("flow change did not take extra cycle");
  a_flush_once: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    s_flow_op |=> ##4 state_r == MCUIET_ST_RUN)
    else $error("flush cycle longer than one cycle");
  a_jump_target: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && is_jmp |=> pc_r == $past(tgt) && fetch_r.addr == pc_r)
    else $error("jump target not loaded");
  a_call_save: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && op_w == MCUIET_OP_CALL |=> ret_r == $past(pc_r))
    else $error("call did not save return address");
  a_low_jump: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && pc_low_wr && !is_jmp |=> pc_r[7:0] == $past(wr_v))
    else $error("counter low write did not jump");
  a_seq_step: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && !flow_w && op_w != MCUIET_OP_HALT |=>
      pc_r == $past(pc_r) + 12'h001 && state_r == MCUIET_ST_RUN)
    else $error("plain instruction did not step");
  a_halt_stay: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_r == MCUIET_ST_HALT |=> state_r == MCUIET_ST_HALT && $stable(pc_r))
    else $error("halted core moved");
  a_add_carry: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && is_alu && aop == MCUIET_ALU_ADD |=>
      flags_r.carry == ($past({1'b0, acc_r}) + $past({1'b0, opnd}) > 9'h0FF))
    else $error("add carry wrong");
  a_table_hold: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    s_table_op |=> pc_r == $past(pc_r) && fetch_r.table_rd)
    else $error("table read lost the next instruction");
  a_table_byte: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    s_table_op |=> ##1 tab_r == $past(PROG_DATA_IN[7:0]))
    else $error("table byte not captured");
  a_zero_flag: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && is_alu |=> flags_r.zero == ($past(res) == 8'h00))
    else $error("zero flag does not follow result");
  a_skip_next: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    exec && skip_w |=> pc_r == $past(pc_r) + 12'h001 && state_r == MCUIET_ST_FLUSH)
    else $error("taken skip did not pass over next word");
  a_wdt_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    wdt_r |=> !wdt_r)
    else $error("watchdog clear longer than one clock");
endmodule
`default_nettype wire

// [tb/mcu_instruction_execution_timing_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_execution_timing_bench;
  import mcuiet_pkg::*;
  logic                clk;
  logic                rst_b;
  logic [15:0]         mem [0:4095];
  logic [15:0]         prog_data;
  mcuiet_fetch_t       fetch;
  logic [7:0]          acc;
  mcuiet_flags_t       flags;
  logic [7:0]          tab_data;
  logic                cyc_end;
  logic                halted;
  logic                wdt;
  int                  n_mismatch;
  int                  compares;
  int                  base;
  int                  cyc;
  logic                saw_tab;
  logic                saw_wdt;

  // Program memory is combinational, as the core expects
  assign prog_data = mem[fetch.addr];

  mcuiet_core mcuiet_core_i (
    .CLK_IN         (clk),
    .RST_B_IN       (rst_b),
    .FETCH_OUT      (fetch),
    .PROG_DATA_IN   (prog_data),
    .ACC_OUT        (acc),
    .FLAGS_OUT      (flags),
    .TABLE_DATA_OUT (tab_data),
    .CYCLE_END_OUT  (cyc_end),
    .HALTED_OUT     (halted),
    .WDT_CLEAR_OUT  (wdt)
  );

  always #20 clk = ~clk;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Unused words halt, so a stray fetch cannot run away
  task automatic clr();
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'hD000;
    end
  endtask

  // Reset, run to halt, count instruction cycles
  task automatic run_prog(output int cycles);
    int gap;
    int n;
    logic [PC_W-1:0] stop_addr;
    cycles = 0;
    gap = 0;
    saw_tab = 1'b0;
    saw_wdt = 1'b0;
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    for (n = 0; n < 600 && halted !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      gap++;
      if (fetch.table_rd === 1'b1) saw_tab = 1'b1;
      if (wdt === 1'b1) saw_wdt = 1'b1;
      if (cyc_end === 1'b1) begin
        if (cycles > 0) check("cycle gap", 16'h0004, 16'(gap));
        cycles++;
        gap = 0;
      end
    end
    if (n >= 600) begin
      n_mismatch++;
      $display("unexpected halt wait expected 1 seen 0");
      print_verdict();
    end
    // Nothing may run once halted; only the phase counter keeps going
    stop_addr = fetch.addr;
    repeat (20) begin
      @(posedge clk);
      #1;
      check("fetch address in halt", 16'(stop_addr), 16'(fetch.addr));
    end
  endtask

  task automatic t_base();
    clr();
    mem[0] = 16'h4011;
    mem[1] = 16'hD000;
    mem[2] = 16'h4055;
    run_prog(base);
    check("acc after halt", 16'h0011, {8'h0, acc});
  endtask

  task automatic t_jump();
    clr();
    mem[0] = 16'h9005;
    mem[1] = 16'h4022;
    mem[5] = 16'h4033;
    run_prog(cyc);
    check("jump acc", 16'h0033, {8'h0, acc});
    check("jump cycles", 16'(base + 2), 16'(cyc));
  endtask

  task automatic t_call();
    clr();
    mem[0] = 16'hA010;
    mem[1] = 16'h1001;
    mem[16] = 16'h4040;
    mem[17] = 16'hB000;
    run_prog(cyc);
    check("call acc", 16'h0041, {8'h0, acc});
    check("call cycles", 16'(base + 5), 16'(cyc));
  endtask

  task automatic t_pc_low();
    clr();
    mem[0] = 16'h4005;
    mem[1] = {8'h30, PC_LOW_ADDR};
    mem[2] = 16'h4077;
    run_prog(cyc);
    check("pc low acc", 16'h0005, {8'h0, acc});
    check("pc low cycles", 16'(base + 2), 16'(cyc));
  endtask

  task automatic t_skip(logic [7:0] v, logic [7:0] e, int extra);
    clr();
    mem[0] = {8'h40, v};
    mem[1] = 16'h3020;
    mem[2] = 16'hF020;
    mem[3] = 16'h4099;
    mem[4] = 16'h1003;
    run_prog(cyc);
    check("skip acc", {8'h0, e}, {8'h0, acc});
    check("skip cycles", 16'(base + extra), 16'(cyc));
  endtask

  task automatic t_alu(logic [2:0] op, logic [7:0] a, logic [7:0] b, logic [7:0] e,
                       logic ez, logic ec);
    clr();
    mem[0] = {8'h40, a};
    mem[1] = {4'h1, 1'b0, op, b};
    run_prog(cyc);
    check("alu acc", {8'h0, e}, {8'h0, acc});
    check("zero flag", {15'h0, ez}, {15'h0, flags.zero});
    if (ec !== 1'bx) check("carry flag", {15'h0, ec}, {15'h0, flags.carry});
  endtask

  task automatic t_bits();
    clr();
    mem[0] = 16'h40A5;
    mem[1] = 16'h3040;
    mem[2] = 16'h5140;
    mem[3] = 16'h6740;
    mem[4] = 16'h4000;
    mem[5] = 16'h2040;
    run_prog(cyc);
    check("bit ops acc", 16'h0027, {8'h0, acc});
  endtask

  task automatic t_table();
    clr();
    // Table pointer low byte comes from data memory, so store it first
    mem[0] = 16'h4045;
    mem[1] = 16'h3045;
    mem[2] = 16'h4003;
    mem[3] = 16'hC045;
    mem[4] = 16'hE000;
    mem[12'h345] = 16'h12AB;
    run_prog(cyc);
    check("table byte", 16'h00AB, {8'h0, tab_data});
    check("table fetch", 16'h0001, {15'h0, saw_tab});
    check("table cycles", 16'(base + 5), 16'(cyc));
    check("watchdog pulse", 16'h0001, {15'h0, saw_wdt});
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    n_mismatch = 0;
    compares = 0;
    clr();
    repeat (10) @(posedge clk);
    t_base();
    t_jump();
    t_call();
    t_pc_low();
    t_skip(8'h00, 8'h03, 4);
    t_skip(8'h01, 8'h9C, 4);
    t_alu(3'h0, 8'hFF, 8'h01, 8'h00, 1'b1, 1'b1);
    t_alu(3'h0, 8'h10, 8'h20, 8'h30, 1'b0, 1'b0);
    t_alu(3'h1, 8'h00, 8'h01, 8'hFF, 1'b0, 1'b0);
    t_alu(3'h1, 8'h05, 8'h05, 8'h00, 1'b1, 1'b1);
    t_alu(3'h2, 8'hF0, 8'h0F, 8'h00, 1'b1, 1'b0);
    t_alu(3'h3, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    t_alu(3'h4, 8'h5A, 8'h5A, 8'h00, 1'b1, 1'b0);
    t_alu(3'h5, 8'hFF, 8'hFF, 8'h00, 1'b1, 1'bx);
    t_alu(3'h6, 8'h7F, 8'h7F, 8'h80, 1'b0, 1'bx);
    t_alu(3'h7, 8'h01, 8'h01, 8'h00, 1'b1, 1'bx);
    t_alu(3'h4, 8'h00, 8'hC1, 8'h83, 1'b0, 1'b0);
    t_alu(3'h4, 8'h00, 8'hE1, 8'hC2, 1'b0, 1'b1);
    t_alu(3'h4, 8'h00, 8'hA1, 8'h50, 1'b0, 1'b1);
    t_bits();
    t_table();
    print_verdict();
  end
endmodule
`default_nettype wire
